// ==== design/awil_regs.vh ====
// register offsets, fields and timing constants for the alarm and warning input logic
`ifndef AWIL_REGS_VH
`define AWIL_REGS_VH
`define AWIL_OFF_POLARITY 12'h000
`define AWIL_OFF_CONTROL 12'h004
`define AWIL_OFF_STATUS 12'h008
`define AWIL_OFF_INT_STATUS 12'h00C
`define AWIL_OFF_INT_MASK 12'h010
`define AWIL_OFF_W3_LIMIT 12'h014
`define AWIL_OFF_W4_LIMIT 12'h018
`define AWIL_OFF_BASE_LIMIT 12'h01C
`define AWIL_OFF_ACT_LIMIT 12'h020
`define AWIL_OFF_SNAP_MEAS 12'h024
`define AWIL_OFF_RAW 12'h028
`define AWIL_CTL_START 0
`define AWIL_CTL_STOP 1
`define AWIL_CTL_CLR_OP 2
`define AWIL_CTL_CLR_SUP 3
`define AWIL_ST_RUN 0
`define AWIL_ST_FIRE 1
`define AWIL_ST_CONTACTOR 2
`define AWIL_ST_LATCH 3
`define AWIL_ST_CAUSE_LSB 4
`define AWIL_ST_WARN_LSB 8
`define AWIL_INT_ALARM 0
`define AWIL_INT_WARN_ON 1
`define AWIL_INT_WARN_OFF 2
`define AWIL_QUAL_ZC 3
`define AWIL_SHUT_ZC 3
`define AWIL_PWR_LOSS_MS 5000
`define AWIL_CLK_MHZ 250
`define AWIL_W3_LIMIT_RST 16'h0064
`define AWIL_W4_LIMIT_RST 16'h0032
`define AWIL_BASE_LIMIT_RST 16'h012C
`endif

// ==== design/awil_top.v ====
// alarm, interlock and warning input qualification and shutdown logic with apb registers
//
// Overview of operation
// - per-input polarity: set bit means voltage absent active
// - four alarm inputs, polarity set by software
// - alarm valid after three consecutive active zero-crosses
// - qualified alarm while running stops firing at once
// - three more zero-crosses, then drop contactor, annunciate
// - alarm lights led, latches alarm and stop relays
// - record causing input, readable by both terminals
// - snapshot measurements taken just before trip
// - alarm stays latched after input returns inactive
// - clear by operator, supervisor, or long power loss
// - interlock behaves exactly like an alarm input
// - four warnings, polarity, same qualification as alarms
// - warnings self-cancel when input goes inactive
// - warnings one and two only annunciate
// - warning three or four imposes reduced current limit
// - warning four limit overrides warning three limit
`timescale 1ns/1ps
`include "awil_regs.vh"
module awil_top #(
    parameter PWR_LOSS_CYCLES = `AWIL_PWR_LOSS_MS * 1000 * `AWIL_CLK_MHZ,
    parameter MEAS_W = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [8:0] field_in,
    input wire zero_cross,
    input wire ctrl_power_ok,
    input wire [MEAS_W-1:0] meas_in,
    output reg fire_enable,
    output reg contactor_on,
    output reg alarm_led,
    output reg alarm_relay,
    output reg alarm_relay_led,
    output reg stop_relay,
    output reg stop_relay_led,
    output reg [15:0] current_limit,
    output reg irq
);
    // ----------------------------------------------------------------
    // input synchronisers and zero-cross edge
    // ----------------------------------------------------------------
    reg [8:0] in_meta_reg;
    reg [8:0] in_sync_reg;
    reg [2:0] zc_reg;
    reg pok_meta_reg;
    reg pok_sync_reg;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_meta_reg <= 9'h000;
            in_sync_reg <= 9'h000;
            zc_reg <= 3'h0;
            pok_meta_reg <= 1'b0;
            pok_sync_reg <= 1'b0;
        end else begin
            in_meta_reg <= field_in;
            in_sync_reg <= in_meta_reg;
            zc_reg <= {zc_reg[1:0], zero_cross};
            pok_meta_reg <= ctrl_power_ok;
            pok_sync_reg <= pok_meta_reg;
        end
    end
    wire zc_evt = zc_reg[1] ^ zc_reg[2];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg [8:0] polarity_reg;
    reg [15:0] w3_limit_reg;
    reg [15:0] w4_limit_reg;
    reg [15:0] base_limit_reg;
    reg [2:0] int_mask_reg;
    reg [2:0] int_status_reg;
    reg [MEAS_W-1:0] snap_reg;
    reg [MEAS_W-1:0] meas_prev_reg;

    // address decode shared by strobes
    function reg_hit;
        input [11:0] addr;
        input [11:0] offset;
        begin
            reg_hit = (addr == offset);
        end
    endfunction

    wire [8:0] active = in_sync_reg ^ polarity_reg;
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    wire wr_ctl = wr && reg_hit(paddr, `AWIL_OFF_CONTROL);
    wire start_cmd = wr_ctl & pwdata[`AWIL_CTL_START];
    wire stop_cmd = wr_ctl & pwdata[`AWIL_CTL_STOP];
    wire clr_cmd = wr_ctl & (pwdata[`AWIL_CTL_CLR_OP] | pwdata[`AWIL_CTL_CLR_SUP]);

    // ----------------------------------------------------------------
    // zero-cross qualification per input
    // ----------------------------------------------------------------
    wire [8:0] qual;
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi = gi + 1) begin : g_q
            reg [1:0] cnt_reg;
            reg q_reg;
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_reg <= 2'h0;
                    q_reg <= 1'b0;
                end else if (!active[gi]) begin
                    cnt_reg <= 2'h0;
                    q_reg <= 1'b0;
                end else if (zc_evt) begin
                    if (cnt_reg == 2'd`AWIL_QUAL_ZC - 2'd1) begin
                        q_reg <= 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg + 2'd1;
                    end
                end
            end
            assign qual[gi] = q_reg;
        end
    endgenerate
    // bits 3:0 alarms, 4 interlock, 8:5 warnings
    wire [4:0] trip_src = qual[4:0];
    wire [3:0] warn = qual[8:5];

    // ----------------------------------------------------------------
    // run and shutdown sequencer
    // ----------------------------------------------------------------
    localparam S_IDLE = 2'd0;
    localparam S_RUN = 2'd1;
    localparam S_WAIT = 2'd2;
    localparam S_TRIP = 2'd3;
    reg [1:0] state_reg;
    reg [1:0] sd_cnt_reg;
    reg latched_reg;
    reg [4:0] cause_reg;
    reg [31:0] loss_cnt_reg;
    wire long_loss = loss_cnt_reg >= PWR_LOSS_CYCLES;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loss_cnt_reg <= 32'h0;
        end else if (pok_sync_reg) begin
            loss_cnt_reg <= 32'h0;
        end else if (!long_loss) begin
            loss_cnt_reg <= loss_cnt_reg + 32'h1;
        end
    end
    wire trip_now = (state_reg == S_RUN) && (trip_src != 5'h00);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= S_IDLE;
            sd_cnt_reg <= 2'h0;
            latched_reg <= 1'b0;
            cause_reg <= 5'h00;
            snap_reg <= {MEAS_W{1'b0}};
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (start_cmd && !latched_reg && trip_src == 5'h00) begin
                        state_reg <= S_RUN;
                    end
                end
                S_RUN: begin
                    if (trip_now) begin
                        state_reg <= S_WAIT;
                        sd_cnt_reg <= 2'h0;
                        latched_reg <= 1'b1;
                        cause_reg <= trip_src;
                        snap_reg <= meas_prev_reg;
                    end else if (stop_cmd) begin
                        state_reg <= S_IDLE;
                    end
                end
                S_WAIT: begin
                    if (zc_evt) begin
                        if (sd_cnt_reg == 2'd`AWIL_SHUT_ZC - 2'd1) begin
                            state_reg <= S_TRIP;
                        end else begin
                            sd_cnt_reg <= sd_cnt_reg + 2'd1;
                        end
                    end
                end
                S_TRIP: begin
                    if (clr_cmd || long_loss) begin
                        state_reg <= S_IDLE;
                        latched_reg <= 1'b0;
                        cause_reg <= 5'h00;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // firing and contactor drive
    // ----------------------------------------------------------------
    wire annun = state_reg == S_TRIP;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fire_enable <= 1'b0;
            contactor_on <= 1'b0;
        end else begin
            fire_enable <= (state_reg == S_RUN) && !trip_now && !stop_cmd;
            contactor_on <= (state_reg == S_RUN) || (state_reg == S_WAIT);
        end
    end

    // ----------------------------------------------------------------
    // alarm relay and indicators
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_led <= 1'b0;
            alarm_relay <= 1'b0;
            alarm_relay_led <= 1'b0;
        end else begin
            alarm_led <= annun;
            alarm_relay <= annun;
            alarm_relay_led <= annun;
        end
    end

    // ----------------------------------------------------------------
    // stop relay and indicator
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_relay <= 1'b0;
            stop_relay_led <= 1'b0;
        end else begin
            stop_relay <= annun;
            stop_relay_led <= annun;
        end
    end

    // ----------------------------------------------------------------
    // current limit selection
    // ----------------------------------------------------------------
    reg [15:0] limit_next;
    always @* begin
        limit_next = base_limit_reg;
        if (warn[3]) begin
            limit_next = w4_limit_reg;
        end else if (warn[2]) begin
            limit_next = w3_limit_reg;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            current_limit <= `AWIL_BASE_LIMIT_RST;
        end else begin
            current_limit <= limit_next;
        end
    end

    // ----------------------------------------------------------------
    // measurement history for the trip snapshot
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meas_prev_reg <= {MEAS_W{1'b0}};
        end else begin
            meas_prev_reg <= meas_in;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and apb slave
    // ----------------------------------------------------------------
    reg [3:0] warn_prev_reg;
    wire [2:0] int_evt = {|(warn_prev_reg & ~warn), |(warn & ~warn_prev_reg), trip_now};
    wire [2:0] int_clr = (wr && reg_hit(paddr, `AWIL_OFF_INT_STATUS)) ? pwdata[2:0] : 3'h0;
    wire [31:0] status_word = {19'h0, warn, cause_reg, latched_reg,
                               contactor_on, fire_enable, state_reg != S_IDLE};
    reg [31:0] rdata_next;
    reg addr_ok;
    always @* begin
        rdata_next = 32'h0;
        addr_ok = 1'b1;
        case (paddr)
            `AWIL_OFF_POLARITY: rdata_next = {23'h0, polarity_reg};
            `AWIL_OFF_CONTROL: rdata_next = 32'h0;
            `AWIL_OFF_STATUS: rdata_next = status_word;
            `AWIL_OFF_INT_STATUS: rdata_next = {29'h0, int_status_reg};
            `AWIL_OFF_INT_MASK: rdata_next = {29'h0, int_mask_reg};
            `AWIL_OFF_W3_LIMIT: rdata_next = {16'h0, w3_limit_reg};
            `AWIL_OFF_W4_LIMIT: rdata_next = {16'h0, w4_limit_reg};
            `AWIL_OFF_BASE_LIMIT: rdata_next = {16'h0, base_limit_reg};
            `AWIL_OFF_ACT_LIMIT: rdata_next = {16'h0, current_limit};
            `AWIL_OFF_SNAP_MEAS: rdata_next = {{(32-MEAS_W){1'b0}}, snap_reg};
            `AWIL_OFF_RAW: rdata_next = {23'h0, active};
            default: addr_ok = 1'b0;
        endcase
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn_prev_reg <= 4'h0;
            int_status_reg <= 3'h0;
            irq <= 1'b0;
        end else begin
            warn_prev_reg <= warn;
            int_status_reg <= (int_status_reg & ~int_clr) | int_evt;
            irq <= |(((int_status_reg & ~int_clr) | int_evt) & int_mask_reg);
        end
    end

    // ----------------------------------------------------------------
    // apb response, one access cycle after setup
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            prdata <= (psel & ~penable & ~pwrite) ? rdata_next : 32'h0;
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            polarity_reg <= 9'h000;
            w3_limit_reg <= `AWIL_W3_LIMIT_RST;
            w4_limit_reg <= `AWIL_W4_LIMIT_RST;
            base_limit_reg <= `AWIL_BASE_LIMIT_RST;
            int_mask_reg <= 3'h0;
        end else begin
            if (wr && pready) begin
                case (paddr)
                    `AWIL_OFF_POLARITY: polarity_reg <= pwdata[8:0];
                    `AWIL_OFF_INT_MASK: int_mask_reg <= pwdata[2:0];
                    `AWIL_OFF_W3_LIMIT: w3_limit_reg <= pwdata[15:0];
                    `AWIL_OFF_W4_LIMIT: w4_limit_reg <= pwdata[15:0];
                    `AWIL_OFF_BASE_LIMIT: base_limit_reg <= pwdata[15:0];
                    default: polarity_reg <= polarity_reg;
                endcase
            end
        end
    end
endmodule

// ==== tb/awil_field.sv ====
// field contacts and mains zero-cross source
`timescale 1ns/1ps
module awil_field #(
    parameter HALF = 20
) (
    input wire pclk,
    input wire [8:0] closed,
    output wire [8:0] field_in,
    output reg zero_cross
);
    // closed contact puts voltage on the input
    assign field_in = closed;
    // mains square wave, free running
    initial begin
        zero_cross = 1'b0;
        forever begin
            repeat (HALF) @(posedge pclk);
            zero_cross <= ~zero_cross;
        end
    end
endmodule

// ==== tb/awil_asserts.sv ====
// concurrent checks on the alarm and warning input logic ports
`timescale 1ns/1ps
`include "awil_regs.vh"
module awil_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire ctrl_power_ok,
    input wire fire_enable,
    input wire contactor_on,
    input wire alarm_led,
    input wire alarm_relay,
    input wire alarm_relay_led,
    input wire stop_relay,
    input wire stop_relay_led
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire wr_ctl = psel && penable && pready && pwrite && paddr == `AWIL_OFF_CONTROL;
    sequence s_setup; psel && !penable; endsequence
    sequence s_trip; $fell(fire_enable) ##0 contactor_on; endsequence
    property p_ready_next; s_setup |=> pready; endproperty
    property p_ready_one; pready |=> !pready; endproperty
    property p_err_zero; pready && pslverr |-> prdata == 32'h0; endproperty
    property p_fire_cont; fire_enable |-> contactor_on; endproperty
    property p_relays; alarm_relay |-> stop_relay && alarm_led && alarm_relay_led && stop_relay_led; endproperty
    property p_quiet; alarm_relay |-> !fire_enable && !contactor_on; endproperty
    property p_trip_wait; s_trip |=> contactor_on [*2]; endproperty
    property p_annun; $rose(alarm_relay) |-> $fell(contactor_on); endproperty
    property p_latch; $fell(alarm_relay) |-> $past(wr_ctl) || $past(wr_ctl, 2) || !ctrl_power_ok; endproperty
    property p_no_start; alarm_relay |=> !$rose(fire_enable); endproperty
    a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
    a_ready_one: assert property (p_ready_one) else $error("ready longer than one cycle");
    a_err_zero: assert property (p_err_zero) else $error("error read not zero");
    a_fire_cont: assert property (p_fire_cont) else $error("firing without contactor");
    a_relays: assert property (p_relays) else $error("alarm outputs not together");
    a_quiet: assert property (p_quiet) else $error("firing during alarm");
    a_trip_wait: assert property (p_trip_wait) else $error("contactor dropped too soon");
    a_annun: assert property (p_annun) else $error("annunciation without contactor drop");
    a_latch: assert property (p_latch) else $error("alarm cleared without cause");
    a_no_start: assert property (p_no_start) else $error("start while latched");
endmodule
bind awil_top awil_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_power_ok(ctrl_power_ok), .fire_enable(fire_enable), .contactor_on(contactor_on),
    .alarm_led(alarm_led), .alarm_relay(alarm_relay), .alarm_relay_led(alarm_relay_led),
    .stop_relay(stop_relay), .stop_relay_led(stop_relay_led));

// ==== tb/testbench.sv ====
// self-checking bench for the alarm and warning input logic
`timescale 1ns/1ps
`include "awil_regs.vh"
module testbench;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ctrl_power_ok, zero_cross, er, irq;
    logic fire_enable, contactor_on, alarm_led, alarm_relay, alarm_relay_led, stop_relay, stop_relay_led;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0] closed, field_in;
    logic [15:0] current_limit;
    int failures = 0;
    int samples_checked = 0;
    int cycles = 0;
    awil_field u_field (.pclk(pclk), .closed(closed), .field_in(field_in), .zero_cross(zero_cross));
    awil_top #(.PWR_LOSS_CYCLES(50)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .field_in(field_in), .zero_cross(zero_cross), .ctrl_power_ok(ctrl_power_ok), .meas_in(16'h1234),
        .fire_enable(fire_enable), .contactor_on(contactor_on), .alarm_led(alarm_led), .alarm_relay(alarm_relay),
        .alarm_relay_led(alarm_relay_led), .stop_relay(stop_relay), .stop_relay_led(stop_relay_led),
        .current_limit(current_limit), .irq(irq));
    task print_verdict;
        if (failures == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task wait_bit(input logic relay, input logic v);
        int n;
        n = 0;
        while ((relay ? alarm_relay : fire_enable) !== v && n < 600) begin @(posedge pclk); n++; end
    endtask
    task t_reset;
        chk(current_limit, 32'h012C);
        apb(1'b0, `AWIL_OFF_W3_LIMIT, 32'h0); chk(rd, 32'h0064);
        apb(1'b0, `AWIL_OFF_W4_LIMIT, 32'h0); chk(rd, 32'h0032);
        apb(1'b0, 12'h02C, 32'h0); chk({er, rd[30:0]}, 32'h80000000);
        apb(1'b1, `AWIL_OFF_INT_MASK, 32'h1);
    endtask
    task t_alarm;
        apb(1'b1, `AWIL_OFF_CONTROL, 32'h1);
        apb(1'b0, `AWIL_OFF_STATUS, 32'h0); chk(rd[1], 1'b1);
        closed <= 9'h002;
        wait_bit(1'b0, 1'b0); chk({alarm_relay, contactor_on}, 2'b01);
        wait_bit(1'b1, 1'b1);
        chk({stop_relay_led, alarm_relay_led, stop_relay, alarm_led, contactor_on, irq}, 6'h3D);
        apb(1'b0, `AWIL_OFF_STATUS, 32'h0); chk(rd[8:3], 6'h05);
        apb(1'b0, `AWIL_OFF_SNAP_MEAS, 32'h0); chk(rd[15:0], 16'h1234);
        closed <= 9'h000;
        repeat (200) @(posedge pclk);
        chk(alarm_relay, 1'b1);
        apb(1'b1, `AWIL_OFF_CONTROL, 32'h1);
        repeat (4) @(posedge pclk);
        chk(fire_enable, 1'b0);
        apb(1'b1, `AWIL_OFF_CONTROL, 32'h4);
        repeat (2) @(posedge pclk); chk(alarm_relay, 1'b0);
        apb(1'b1, `AWIL_OFF_INT_STATUS, 32'h1); @(posedge pclk); chk(irq, 1'b0);
    endtask
    task t_ilk;
        apb(1'b1, `AWIL_OFF_CONTROL, 32'h1);
        apb(1'b1, `AWIL_OFF_POLARITY, 32'h010);
        wait_bit(1'b1, 1'b1);
        apb(1'b0, `AWIL_OFF_STATUS, 32'h0); chk(rd[8:3], 6'h21);
        ctrl_power_ok <= 1'b0;
        repeat (80) @(posedge pclk);
        chk(alarm_relay, 1'b0);
        ctrl_power_ok <= 1'b1;
        apb(1'b1, `AWIL_OFF_POLARITY, 32'h0);
    endtask
    task t_warn;
        closed <= 9'h080; repeat (150) @(posedge pclk); chk(current_limit, 32'h0064);
        closed <= 9'h180; repeat (150) @(posedge pclk); chk(current_limit, 32'h0032);
        closed <= 9'h020; repeat (150) @(posedge pclk); chk(current_limit, 32'h012C);
        apb(1'b0, `AWIL_OFF_STATUS, 32'h0); chk(rd[12:9], 4'h1);
        closed <= 9'h000; repeat (150) @(posedge pclk);
        apb(1'b0, `AWIL_OFF_STATUS, 32'h0); chk(rd[12:9], 4'h0);
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict;
        end
    end
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        closed = 9'h0; ctrl_power_ok = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_alarm;
        t_ilk;
        t_warn;
        print_verdict;
    end
endmodule
